// ---- inc/clrp_pkg.sv ----
package clrp_pkg;

  // operation select from the decode path
  typedef enum logic [2:0] {
    CLRP_OP_NONE,
    CLRP_OP_OR,
    CLRP_OP_POWER_OFF_ENABLE,
    CLRP_OP_POWER_OFF,
    CLRP_OP_ROTATE_RIGHT_CARRY,
    CLRP_OP_BIT_CLEAR
  } clrp_op_e;

  localparam int CLRP_NIBBLE_W = 4;
  localparam int CLRP_ADDR_W = 8;
  localparam int CLRP_BIT_SEL_W = 2;
  localparam int CLRP_MSB = 3;
  localparam int CLRP_LSB = 0;
  localparam logic [3:0] CLRP_ACC_RST = 4'h0;
  localparam logic CLRP_CARRY_RST = 1'b0;
  localparam logic [7:0] CLRP_ADDR_RST = 8'h00;
  localparam logic [3:0] CLRP_NIBBLE_ONE = 4'h1;

endpackage : clrp_pkg

// ---- verilog/clrp_alu.sv ----
`timescale 1ns/10ps
`default_nettype none
module clrp_alu
  import clrp_pkg::*;
(
  input wire clrp_op_e op,
  input wire logic [3:0] acc,
  input wire logic carry,
  input wire logic [3:0] mem_data,
  input wire logic [1:0] bit_sel,
  output logic [3:0] acc_res,
  output logic carry_res,
  output logic [3:0] mem_res,
  output logic acc_we,
  output logic carry_we,
  output logic mem_we
);

  always_comb begin
    acc_res = acc;
    carry_res = carry;
    mem_res = mem_data;
    acc_we = 1'b0;
    carry_we = 1'b0;
    mem_we = 1'b0;
    unique case (op)
      CLRP_OP_OR: begin
        acc_res = acc | mem_data;
        acc_we = 1'b1;
      end
      CLRP_OP_ROTATE_RIGHT_CARRY: begin
        acc_res = {carry, acc[CLRP_MSB:1]};
        carry_res = acc[CLRP_LSB];
        acc_we = 1'b1;
        carry_we = 1'b1;
      end
      CLRP_OP_BIT_CLEAR: begin
        mem_res = mem_data & ~(CLRP_NIBBLE_ONE << bit_sel);
        mem_we = 1'b1;
      end
      CLRP_OP_NONE, CLRP_OP_POWER_OFF_ENABLE, CLRP_OP_POWER_OFF: begin
        acc_we = 1'b0;
      end
      default: begin
        acc_we = 1'b0;
      end
    endcase
  end

endmodule // clrp_alu
`default_nettype wire

// ---- verilog/clrp_core.sv ----
// Behaviour
// - OR accumulator with nibble at data_pointer into accumulator; carry_flag unchanged.
// - power_off_op enters RAM back-up only directly after power_off_enable_op.
// - rotate accumulator right through carry_flag; old carry to bit 3.
// - bit_clear_op clears immediate-selected bit of nibble at data_pointer only.
`timescale 1ns/10ps
`default_nettype none
module clrp_core
  import clrp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // instruction from decode
  input wire logic instr_valid,
  input wire clrp_op_e instr_op,
  input wire logic [1:0] bit_sel,
  // memory read side
  input wire logic [7:0] data_pointer,
  input wire logic [3:0] mem_rd_data,
  // core state
  output logic [3:0] acc_ff,
  output logic carry_flag_ff,
  // memory write side
  output logic mem_wr_en_ff,
  output logic [7:0] mem_wr_addr_ff,
  output logic [3:0] mem_wr_data_ff,
  // back-up state
  output logic backup_ff
);

  ////////////////////////////////////////////////////////////////////////
  // decode helper
  function automatic logic op_hit(
    input logic valid,
    input clrp_op_e op,
    input clrp_op_e want
  );
    return valid && (op == want);
  endfunction

  // codes past the last operation are treated as no operation
  function automatic logic op_legal(
    input clrp_op_e op
  );
    logic ok;
    ok = 1'b0;
    unique case (op)
      CLRP_OP_NONE, CLRP_OP_OR, CLRP_OP_POWER_OFF_ENABLE: ok = 1'b1;
      CLRP_OP_POWER_OFF, CLRP_OP_ROTATE_RIGHT_CARRY, CLRP_OP_BIT_CLEAR: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // power-off decode
  logic do_enable;
  logic do_power_off;
  logic op_ok;

  assign do_enable = op_hit(instr_valid, instr_op, CLRP_OP_POWER_OFF_ENABLE);
  assign do_power_off = op_hit(instr_valid, instr_op, CLRP_OP_POWER_OFF);
  assign op_ok = op_legal(instr_op);

  ////////////////////////////////////////////////////////////////////////
  // alu results
  logic [3:0] acc_res;
  logic carry_res;
  logic [3:0] mem_res;
  logic acc_we;
  logic carry_we;
  logic mem_we;
  clrp_op_e op_eff;

  // idle cycles and unknown codes reach the alu as no operation
  assign op_eff = (instr_valid && op_ok) ? instr_op : CLRP_OP_NONE;

  // combinational datapath
  clrp_alu u_alu (
    .op(op_eff),
    .acc(acc_ff),
    .carry(carry_flag_ff),
    .mem_data(mem_rd_data),
    .bit_sel(bit_sel),
    .acc_res(acc_res),
    .carry_res(carry_res),
    .mem_res(mem_res),
    .acc_we(acc_we),
    .carry_we(carry_we),
    .mem_we(mem_we)
  );

  ////////////////////////////////////////////////////////////////////////
  // next-state signals
  logic [3:0] nxt_acc;
  logic nxt_carry_flag;
  logic nxt_mem_wr_en;
  logic [7:0] nxt_mem_wr_addr;
  logic [3:0] nxt_mem_wr_data;
  logic nxt_enable_armed;
  logic nxt_backup;
  logic enable_armed_ff;
  logic power_off_taken;

  ////////////////////////////////////////////////////////////////////////
  // accumulator next value, bit by bit
  genvar gi;
  generate
    for (gi = 0; gi < CLRP_NIBBLE_W; gi++) begin : g_acc_bit
      assign nxt_acc[gi] = acc_we ? acc_res[gi] : acc_ff[gi];
    end
  endgenerate

  // carry only moves on rotate
  always_comb begin
    nxt_carry_flag = carry_flag_ff;
    if (carry_we) begin
      nxt_carry_flag = carry_res;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_ff <= CLRP_ACC_RST;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // carry register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      carry_flag_ff <= CLRP_CARRY_RST;
    end else begin
      carry_flag_ff <= nxt_carry_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory write-back next values
  // the write lands one cycle late; outside forwards a same-address read
  always_comb begin
    nxt_mem_wr_en = mem_we;
    nxt_mem_wr_addr = data_pointer;
  end

  // write data, bit by bit
  generate
    for (gi = 0; gi < CLRP_NIBBLE_W; gi++) begin : g_wr_bit
      assign nxt_mem_wr_data[gi] = mem_res[gi];
    end
  endgenerate

  // write strobe, one cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mem_wr_en_ff <= 1'b0;
    end else begin
      mem_wr_en_ff <= nxt_mem_wr_en;
    end
  end

  // write address
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mem_wr_addr_ff <= CLRP_ADDR_RST;
    end else begin
      mem_wr_addr_ff <= nxt_mem_wr_addr;
    end
  end

  // write data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mem_wr_data_ff <= CLRP_ACC_RST;
    end else begin
      mem_wr_data_ff <= nxt_mem_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-off arming
  // only valid instructions move the arm; idle cycles keep it
  always_comb begin
    nxt_enable_armed = enable_armed_ff;
    if (instr_valid) begin
      nxt_enable_armed = do_enable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enable_armed_ff <= 1'b0;
    end else begin
      enable_armed_ff <= nxt_enable_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // back-up entry
  // power-off without the arm set falls through as no operation
  assign power_off_taken = do_power_off && enable_armed_ff;

  always_comb begin
    nxt_backup = backup_ff;
    if (power_off_taken) begin
      nxt_backup = 1'b1;
    end
  end

  // sticky until reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      backup_ff <= 1'b0;
    end else begin
      backup_ff <= nxt_backup;
    end
  end

endmodule // clrp_core
`default_nettype wire

// ---- sim/clrp_core_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module clrp_core_monitor
  import clrp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire clrp_op_e instr_op,
  input wire logic [1:0] bit_sel,
  input wire logic [7:0] data_pointer,
  input wire logic [3:0] mem_rd_data,
  input wire logic [3:0] acc_ff,
  input wire logic carry_flag_ff,
  input wire logic mem_wr_en_ff,
  input wire logic [7:0] mem_wr_addr_ff,
  input wire logic [3:0] mem_wr_data_ff,
  input wire logic backup_ff
);
  logic armed_ff;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      armed_ff <= 1'b0;
    end else if (instr_valid) begin
      armed_ff <= instr_op == CLRP_OP_POWER_OFF_ENABLE;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence arm_s; instr_valid && instr_op == CLRP_OP_POWER_OFF_ENABLE; endsequence
  sequence off_s; instr_valid && instr_op == CLRP_OP_POWER_OFF; endsequence
  AST_OR: assert property (instr_valid && instr_op == CLRP_OP_OR |=>
    acc_ff == $past(acc_ff | mem_rd_data) && $stable(carry_flag_ff)) else $error("or wrong");
  AST_OFF: assert property (arm_s ##1 off_s |=> backup_ff) else $error("no backup");
  AST_STICKY: assert property (backup_ff |=> backup_ff) else $error("backup dropped");
  AST_NOP: assert property (off_s ##0 !backup_ff ##0 !armed_ff
    |=> !backup_ff && $stable(acc_ff) && $stable(carry_flag_ff)) else $error("nop wrong");
  AST_ROT: assert property (instr_valid && instr_op == CLRP_OP_ROTATE_RIGHT_CARRY |=>
    {acc_ff, carry_flag_ff} == {$past(carry_flag_ff), $past(acc_ff)}) else $error("rotate wrong");
  AST_CLR: assert property (instr_valid && instr_op == CLRP_OP_BIT_CLEAR |=> mem_wr_en_ff &&
    mem_wr_data_ff == ($past(mem_rd_data) & ~(4'h1 << $past(bit_sel))) &&
    mem_wr_addr_ff == $past(data_pointer) && $stable(carry_flag_ff)) else $error("clear wrong");
  AST_NOWR: assert property (!(instr_valid && instr_op == CLRP_OP_BIT_CLEAR) |=> !mem_wr_en_ff)
    else $error("stray write");
endmodule // clrp_core_monitor
`default_nettype wire

// ---- sim/test_cpu_logic_rotate_powerdown_ops.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin failures++; $display("Error %s expected %h seen %h", n, e, s); end end
module test_cpu_logic_rotate_powerdown_ops
  import clrp_pkg::*;
;
  logic clk_sys = 0, sys_rst = 1, instr_valid = 0, carry_flag_ff, mem_wr_en_ff, backup_ff, ec, eb, ew, arm;
  clrp_op_e instr_op = CLRP_OP_NONE;
  logic [1:0] bit_sel = '0;
  logic [7:0] data_pointer = '0, mem_wr_addr_ff, ep;
  logic [3:0] mem_rd_data = '0, acc_ff, mem_wr_data_ff, ea, ed;
  logic [23:0] cs = 24'h68_b4e5;
  int failures = 0, compares = 0, seed = 32'hc254_e55f, i, j;
  always #4 clk_sys = ~clk_sys;
  clrp_core dut_u (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .instr_valid(instr_valid),
    .instr_op(instr_op),
    .bit_sel(bit_sel),
    .data_pointer(data_pointer),
    .mem_rd_data(mem_rd_data),
    .acc_ff(acc_ff),
    .carry_flag_ff(carry_flag_ff),
    .mem_wr_en_ff(mem_wr_en_ff),
    .mem_wr_addr_ff(mem_wr_addr_ff),
    .mem_wr_data_ff(mem_wr_data_ff),
    .backup_ff(backup_ff)
  );
  ////////////////////////////////////////////////////////////
  function automatic void step();
    case (instr_op)
      CLRP_OP_OR: ea = ea | mem_rd_data;
      CLRP_OP_POWER_OFF: eb = eb | arm;
      CLRP_OP_ROTATE_RIGHT_CARRY: {ea, ec} = {ec, ea};
      CLRP_OP_BIT_CLEAR: {ew, ed} = {1'b1, mem_rd_data & ~(4'h1 << bit_sel)};
      default: ;
    endcase
    arm = instr_op == CLRP_OP_POWER_OFF_ENABLE;
  endfunction
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {ea, ec, eb, ew, arm, ep} = '0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 0;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      ew = 0;
      if (sys_rst) begin
        {ea, ec, eb, arm, ep} = '0;
      end else begin
        ep = data_pointer;
        if (instr_valid) step();
      end
      j = i < 8 ? i : i - 201;
      sys_rst <= i == 200;
      instr_valid <= (j >= 0 && j < 8) | 1'($random(seed));
      instr_op <= (j >= 0 && j < 8) ? clrp_op_e'(cs[23-3*j -: 3]) : clrp_op_e'(($random(seed) & 32'h7fff_ffff) % 6);
      bit_sel <= 2'($random(seed));
      mem_rd_data <= 4'($random(seed));
      data_pointer <= 8'($random(seed));
      #1;
      `CHK("acc", ea, acc_ff)
      `CHK("carry", ec, carry_flag_ff)
      `CHK("backup", eb, backup_ff)
      `CHK("wr_en", ew, mem_wr_en_ff)
      `CHK("wr_addr", ep, mem_wr_addr_ff)
      `CHK("wr_data", ew ? ed : mem_wr_data_ff, mem_wr_data_ff)
    end
    conclude();
  end
  initial begin
    #(8 * 2000);
    failures++;
    conclude();
  end
endmodule // test_cpu_logic_rotate_powerdown_ops
bind clrp_core clrp_core_monitor mon_u (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .instr_valid(instr_valid),
  .instr_op(instr_op),
  .bit_sel(bit_sel),
  .data_pointer(data_pointer),
  .mem_rd_data(mem_rd_data),
  .acc_ff(acc_ff),
  .carry_flag_ff(carry_flag_ff),
  .mem_wr_en_ff(mem_wr_en_ff),
  .mem_wr_addr_ff(mem_wr_addr_ff),
  .mem_wr_data_ff(mem_wr_data_ff),
  .backup_ff(backup_ff)
);
`default_nettype wire
